/* hdl/tcpf_pkg.sv */
/*
 tunnel control packet framer: shared lengths, codes, crc and checksum helpers.
 assumes both ends run on one 50 MHz clock.
*/
package tcpf_pkg;
	// ----------------------------------------
	// layer lengths in bytes, then widths and sizes
	// ----------------------------------------
	localparam int ETH_LEN = 14;
	localparam int VLAN_LEN = 4;
	localparam int IP_LEN = 20;
	localparam int UDP_LEN = 8;
	localparam int CTL_LEN = 12;
	localparam int CRC_LEN = 4;
	localparam int AVP_MIN = 6;
	localparam int HDR_MAX = 58;
	localparam int LEN_W = 11;
	localparam int MTU_DEFAULT = 1500;
	localparam int ADDR_SLOTS = 4;
	localparam int FIFO_DEPTH = 2;
	// ----------------------------------------
	// field codes and reset values
	// ----------------------------------------
	localparam logic [15:0] ETYPE_VLAN = 16'h8100;
	localparam logic [15:0] ETYPE_IP = 16'h0800;
	localparam logic [15:0] IP_FLAGS_NO_SPLIT = 16'h4000;
	localparam logic [15:0] CTL_FLAGS_VER = 16'hc803;
	localparam logic [7:0] IP_VER_IHL = 8'h45;
	localparam logic [7:0] IP_PROTO_UDP = 8'h11;
	localparam logic [7:0] IP_TTL = 8'h40;
	localparam logic [31:0] CRC_INIT = 32'hffffffff;
	localparam logic [31:0] CRC_POLY = 32'hedb88320;
	localparam logic [31:0] CRC_RESIDUE = 32'hdebb20e3;
	localparam int GROUP_BIT = 40;

	typedef enum logic [2:0] {CAUSE_NONE, CAUSE_GROUP, CAUSE_HDR, CAUSE_FRAG, CAUSE_CSUM, CAUSE_AVP, CAUSE_CRC,
		CAUSE_ADDR} tcpf_cause_t;

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [31:0] crc32_byte(input logic [31:0] c, input logic [7:0] d);
		logic [31:0] x;
		x = c ^ {24'h000000, d};
		for (int i = 0; i < 8; i++) begin
			x = x[0] ? ((x >> 1) ^ CRC_POLY) : (x >> 1);
		end
		return x;
	endfunction

	function automatic logic [15:0] csum_fold(input logic [31:0] s);
		logic [31:0] t;
		t = {16'h0000, s[15:0]} + {16'h0000, s[31:16]};
		t = {16'h0000, t[15:0]} + {16'h0000, t[31:16]};
		return t[15:0];
	endfunction
endpackage

/* hdl/tcpf_link_if.sv */
/*
 byte stream link from the headend core end to the remote node end.
 assumes both ends share one clock; last marks the final crc byte.
*/
`timescale 1ns/1ns
interface tcpf_link_if;
	logic [7:0] data;
	logic valid;
	logic last;
	logic ready;
	modport core_end (output data, output valid, output last, input ready);
	modport remote_end (input data, input valid, input last, output ready);
endinterface

/* hdl/tcpf_core_end.sv */
/*
 headend core end: builds one tunnel control packet per start and streams it out.
 assumes configuration inputs hold steady from START until DONE or REFUSED,
 and avp bytes arrive on the same clock.
*/
`timescale 1ns/1ns
// Function
// - eth, vlan, ip, udp, control, avps, crc
// - control header: flags/length, connection id, ns, nr
// - avp records back to back until length
// - destination mac must be individual address
// - destination mac is remote or next hop
// - insert and accept optional 4-byte vlan tag
// - vlan priority mapped from code point
// - never fragment; oversize payload refused
// - no_split_flag set on every packet
// - receiver drops fragments, no reassembly
// - configurable 6-bit code point in ds field
// - full 20-byte ipv4 header built and checked
// - remote holds four distinct core endpoint addresses
// - core may target any reported endpoint address
// - security associations before control session starts
// - one endpoint address per control session
module tcpf_core_end #(
	parameter int DEPTH = tcpf_pkg::FIFO_DEPTH,
	parameter int MTU = tcpf_pkg::MTU_DEFAULT
) (
	input wire logic CLK,
	input wire logic RESET_N,
	tcpf_link_if.core_end LINK,
	input wire logic START,
	input wire logic MUTUAL_AUTH,
	input wire logic SA_READY,
	input wire logic [47:0] DST_MAC,
	input wire logic [47:0] SRC_MAC,
	input wire logic VLAN_EN,
	input wire logic [11:0] VLAN_ID,
	input wire logic [5:0] DSCP,
	input wire logic [31:0] SRC_IP,
	input wire logic [31:0] DST_IP,
	input wire logic [15:0] SRC_PORT,
	input wire logic [15:0] DST_PORT,
	input wire logic [31:0] CONN_ID,
	input wire logic [15:0] NS,
	input wire logic [15:0] NR,
	input wire logic [15:0] IDENT,
	input wire logic [10:0] AVP_LEN,
	input wire logic [7:0] AVP_DATA,
	input wire logic AVP_VALID,
	output logic AVP_READY,
	output logic BUSY,
	output logic DONE,
	output logic REFUSED
);
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int HW = tcpf_pkg::HDR_MAX * 8;
	localparam logic [15:0] FIXED_IP = 16'(tcpf_pkg::IP_LEN + tcpf_pkg::UDP_LEN + tcpf_pkg::CTL_LEN);
	localparam logic [15:0] FIXED_UDP = 16'(tcpf_pkg::UDP_LEN + tcpf_pkg::CTL_LEN);
	localparam logic [15:0] FIXED_CTL = 16'(tcpf_pkg::CTL_LEN);
	localparam logic [10:0] AVP_MAX = 11'(MTU - tcpf_pkg::IP_LEN - tcpf_pkg::UDP_LEN - tcpf_pkg::CTL_LEN);

	generate
		if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || MTU < 40 || MTU > 2000) begin : g_bad_param
			$error("tcpf_core_end: DEPTH must be a power of two >= 2 and MTU in 40..2000");
		end
	endgenerate

	typedef enum logic [1:0] {ST_IDLE, ST_HDR, ST_AVP, ST_CRC} tcpf_state_t;

	// ----------------------------------------
	// header image built at start
	// ----------------------------------------
	logic [15:0] tot_len;
	logic [15:0] udp_len;
	logic [15:0] ctl_len;
	logic [15:0] ds_word;
	logic [15:0] ip_csum;
	logic [31:0] csum_sum;
	logic [159:0] ip_hdr;
	logic [63:0] udp_hdr;
	logic [95:0] ctl_hdr;
	logic [31:0] vlan_tag;
	logic [HW-1:0] hdr_image;
	logic start_ok;

	always_comb begin
		tot_len = FIXED_IP + {5'h00, AVP_LEN};
		udp_len = FIXED_UDP + {5'h00, AVP_LEN};
		ctl_len = FIXED_CTL + {5'h00, AVP_LEN};
		ds_word = {tcpf_pkg::IP_VER_IHL, DSCP, 2'b00};
		csum_sum = {16'h0000, ds_word} + {16'h0000, tot_len} + {16'h0000, IDENT}
			+ {16'h0000, tcpf_pkg::IP_FLAGS_NO_SPLIT}
			+ {16'h0000, tcpf_pkg::IP_TTL, tcpf_pkg::IP_PROTO_UDP} + {16'h0000, SRC_IP[31:16]}
			+ {16'h0000, SRC_IP[15:0]} + {16'h0000, DST_IP[31:16]} + {16'h0000, DST_IP[15:0]};
		ip_csum = ~tcpf_pkg::csum_fold(csum_sum);
		// no_split_flag always set, fragment offset zero
		ip_hdr = {ds_word, tot_len, IDENT, tcpf_pkg::IP_FLAGS_NO_SPLIT, tcpf_pkg::IP_TTL, tcpf_pkg::IP_PROTO_UDP, ip_csum,
			SRC_IP, DST_IP};
		udp_hdr = {SRC_PORT, DST_PORT, udp_len, 16'h0000};
		ctl_hdr = {tcpf_pkg::CTL_FLAGS_VER, ctl_len, CONN_ID, NS, NR};
		vlan_tag = {tcpf_pkg::ETYPE_VLAN, DSCP[5:3], 1'b0, VLAN_ID};
		// fields msb first; an untagged image is padded at the tail
		if (VLAN_EN) begin
			hdr_image = {DST_MAC, SRC_MAC, vlan_tag, tcpf_pkg::ETYPE_IP, ip_hdr, udp_hdr, ctl_hdr};
		end else begin
			hdr_image = {DST_MAC, SRC_MAC, tcpf_pkg::ETYPE_IP, ip_hdr, udp_hdr, ctl_hdr, 32'h00000000};
		end
		// group mac, missing security association or oversize payload are refused
		start_ok = !DST_MAC[tcpf_pkg::GROUP_BIT] && (!MUTUAL_AUTH || SA_READY) && (AVP_LEN <= AVP_MAX);
	end

	// ----------------------------------------
	// sequencer and two-entry buffer
	// ----------------------------------------
	tcpf_state_t state, next_state;
	logic [HW-1:0] hdr, next_hdr;
	logic [5:0] hdr_left, next_hdr_left;
	logic [10:0] avp_left, next_avp_left;
	logic [2:0] crc_left, next_crc_left;
	logic [31:0] crc, next_crc;
	logic [8:0] mem [DEPTH];
	logic [PW-1:0] rd_ptr, next_rd_ptr, wr_ptr, next_wr_ptr;
	logic [PW:0] cnt, next_cnt;
	logic next_avp_ready, next_busy, next_done, next_refused;
	logic wr_en, pop;
	logic [8:0] wr_word;

	assign LINK.valid = (cnt != '0);
	assign LINK.data = mem[rd_ptr][7:0];
	assign LINK.last = mem[rd_ptr][8];

	always_comb begin
		next_state = state;
		next_hdr = hdr;
		next_hdr_left = hdr_left;
		next_avp_left = avp_left;
		next_crc_left = crc_left;
		next_crc = crc;
		next_done = 1'b0;
		next_refused = 1'b0;
		wr_en = 1'b0;
		wr_word = 9'h000;
		pop = LINK.valid && LINK.ready;
		case (state)
			ST_IDLE: begin
				if (START && start_ok) begin
					next_hdr = hdr_image;
					next_hdr_left = VLAN_EN ? 6'(tcpf_pkg::HDR_MAX) : 6'(tcpf_pkg::HDR_MAX - tcpf_pkg::VLAN_LEN);
					next_avp_left = AVP_LEN;
					next_crc = tcpf_pkg::CRC_INIT;
					next_state = ST_HDR;
				end else if (START) begin
					next_refused = 1'b1;
				end
			end
			ST_HDR: begin
				if (cnt < (PW + 1)'(DEPTH)) begin
					wr_en = 1'b1;
					wr_word = {1'b0, hdr[HW-1 -: 8]};
					next_hdr = hdr << 8;
					next_hdr_left = hdr_left - 6'h01;
					next_crc = tcpf_pkg::crc32_byte(crc, hdr[HW-1 -: 8]);
					if (hdr_left == 6'h01) begin
						next_state = (avp_left != 11'h000) ? ST_AVP : ST_CRC;
						next_crc_left = 3'(tcpf_pkg::CRC_LEN);
					end
				end
			end
			ST_AVP: begin
				// avp bytes pass through untouched, record framing is the source's
				if (AVP_VALID && AVP_READY) begin
					wr_en = 1'b1;
					wr_word = {1'b0, AVP_DATA};
					next_avp_left = avp_left - 11'h001;
					next_crc = tcpf_pkg::crc32_byte(crc, AVP_DATA);
					if (avp_left == 11'h001) begin
						next_state = ST_CRC;
					end
				end
			end
			ST_CRC: begin
				if (cnt < (PW + 1)'(DEPTH)) begin
					wr_en = 1'b1;
					wr_word = {crc_left == 3'h1, ~crc[7:0]};
					next_crc = crc >> 8;
					next_crc_left = crc_left - 3'h1;
					if (crc_left == 3'h1) begin
						next_done = 1'b1;
						next_state = ST_IDLE;
					end
				end
			end
			default: next_state = ST_IDLE;
		endcase
		next_wr_ptr = wr_en ? wr_ptr + 1'b1 : wr_ptr;
		next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
		next_cnt = cnt + (PW + 1)'(wr_en) - (PW + 1)'(pop);
		// registered ready: room is promised only if a slot is left after this cycle
		next_avp_ready = (next_state == ST_AVP) && (next_cnt < (PW + 1)'(DEPTH));
		next_busy = (next_state != ST_IDLE);
	end

	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			state <= ST_IDLE;
			hdr <= '0;
			hdr_left <= 6'h00;
			avp_left <= 11'h000;
			crc_left <= 3'h0;
			crc <= tcpf_pkg::CRC_INIT;
			rd_ptr <= '0;
			wr_ptr <= '0;
			cnt <= '0;
			AVP_READY <= 1'b0;
			BUSY <= 1'b0;
			DONE <= 1'b0;
			REFUSED <= 1'b0;
		end else begin
			state <= next_state;
			hdr <= next_hdr;
			hdr_left <= next_hdr_left;
			avp_left <= next_avp_left;
			crc_left <= next_crc_left;
			crc <= next_crc;
			rd_ptr <= next_rd_ptr;
			wr_ptr <= next_wr_ptr;
			cnt <= next_cnt;
			AVP_READY <= next_avp_ready;
			BUSY <= next_busy;
			DONE <= next_done;
			REFUSED <= next_refused;
		end
	end

	// storage only, no reset needed: valid comes from cnt
	always_ff @(posedge CLK) begin
		if (wr_en) begin
			mem[wr_ptr] <= wr_word;
		end
	end
endmodule

/* hdl/tcpf_remote_end.sv */
/*
 remote node end: parses and checks tunnel control packets from the link.
 assumes a frame ends with last on its final crc byte; avp bytes are streamed
 before the verdict, so the user must wait for ACCEPT or DROP.
*/
`timescale 1ns/1ns
module tcpf_remote_end #(
	parameter int SLOTS = tcpf_pkg::ADDR_SLOTS
) (
	input wire logic CLK,
	input wire logic RESET_N,
	tcpf_link_if.remote_end LINK,
	input wire logic [31:0] MY_IP,
	input wire logic MUTUAL_AUTH,
	input wire logic SA_READY,
	input wire logic AVP_READY,
	output logic [7:0] AVP_DATA,
	output logic AVP_VALID,
	output logic ACCEPT,
	output logic DROP,
	output tcpf_pkg::tcpf_cause_t DROP_CAUSE,
	output logic [31:0] CONN_ID,
	output logic [15:0] NS,
	output logic [15:0] NR,
	output logic [31:0] PEER_IP,
	output logic [47:0] PEER_MAC,
	output logic VLAN_SEEN,
	output logic [2:0] USER_PRIO,
	output logic [7:0] AVP_RECORDS
);
	generate
		if (SLOTS < 4 || SLOTS > 16) begin : g_bad_param
			$error("tcpf_remote_end: SLOTS must be 4..16");
		end
	endgenerate

	// ----------------------------------------
	// parser state
	// ----------------------------------------
	logic [10:0] pos, next_pos, r, base, avp_end;
	logic [23:0] sh, next_sh;
	logic [15:0] w;
	logic vlan, next_vlan;
	logic [15:0] clen, next_clen;
	logic [31:0] sum, next_sum, crc, next_crc, src_ip, next_src_ip, dst_ip, next_dst_ip;
	logic [9:0] rec_left, next_rec_left, rec_len;
	logic rec_ph, next_rec_ph;
	tcpf_pkg::tcpf_cause_t cause, next_cause, verdict;
	logic [31:0] slot_ip [SLOTS];
	logic [SLOTS-1:0] slot_used, next_slot_used, match;
	logic [31:0] next_slot_ip [SLOTS];
	logic take, fin, avp_byte;
	logic [31:0] n_conn, n_peer_ip;
	logic [15:0] n_ns, n_nr;
	logic [47:0] n_mac;
	logic [2:0] n_prio;
	logic [7:0] n_recs;
	logic n_vseen, n_accept, n_drop, n_avp_valid;
	logic [7:0] n_avp_data;

	assign LINK.ready = !AVP_VALID || AVP_READY;
	assign take = LINK.valid && LINK.ready;

	genvar gi;
	generate
		for (gi = 0; gi < SLOTS; gi++) begin : g_slot
			assign match[gi] = slot_used[gi] && (slot_ip[gi] == src_ip);
		end
	endgenerate

	always_comb begin
		next_pos = pos;
		next_sh = sh;
		next_vlan = vlan;
		next_clen = clen;
		next_sum = sum;
		next_crc = crc;
		next_src_ip = src_ip;
		next_dst_ip = dst_ip;
		next_rec_left = rec_left;
		next_rec_ph = rec_ph;
		next_cause = cause;
		next_slot_used = slot_used;
		next_slot_ip = slot_ip;
		n_conn = CONN_ID;
		n_ns = NS;
		n_nr = NR;
		n_mac = PEER_MAC;
		n_prio = USER_PRIO;
		n_vseen = VLAN_SEEN;
		n_recs = AVP_RECORDS;
		n_peer_ip = PEER_IP;
		n_accept = 1'b0;
		n_drop = 1'b0;
		n_avp_valid = AVP_VALID && !AVP_READY;
		n_avp_data = AVP_DATA;
		verdict = cause;
		base = vlan ? 11'(tcpf_pkg::ETH_LEN + tcpf_pkg::VLAN_LEN) : 11'(tcpf_pkg::ETH_LEN);
		r = pos - base;
		avp_end = base + 11'(tcpf_pkg::IP_LEN + tcpf_pkg::UDP_LEN + tcpf_pkg::CTL_LEN - tcpf_pkg::CTL_LEN) + clen[10:0];
		w = {sh[7:0], LINK.data};
		rec_len = {sh[1:0], LINK.data};
		fin = take && LINK.last;
		avp_byte = 1'b0;
		if (take) begin
			next_sh = {sh[15:0], LINK.data};
			next_pos = pos + 11'h001;
			next_crc = tcpf_pkg::crc32_byte(crc, LINK.data);
			if (pos == 11'h000 && LINK.data[0]) begin
				next_cause = tcpf_pkg::CAUSE_GROUP;
			end
			if (pos == 11'h00d) begin
				next_vlan = (w == tcpf_pkg::ETYPE_VLAN);
				if (w != tcpf_pkg::ETYPE_VLAN && w != tcpf_pkg::ETYPE_IP) begin
					next_cause = tcpf_pkg::CAUSE_HDR;
				end
			end
			if (vlan && pos == 11'h00f) begin
				n_prio = w[15:13];
			end
			if (vlan && pos == 11'h011 && w != tcpf_pkg::ETYPE_IP) begin
				next_cause = tcpf_pkg::CAUSE_HDR;
			end
			if (pos >= base && r < 11'(tcpf_pkg::IP_LEN)) begin
				if (r[0]) begin
					next_sum = sum + {16'h0000, w};
				end
				if (r == 11'h000 && LINK.data != tcpf_pkg::IP_VER_IHL) begin
					next_cause = tcpf_pkg::CAUSE_HDR;
				end
				// more-fragments or nonzero offset: no reassembly, drop as unsupported
				if (r == 11'h007 && w[13:0] != 14'h0000) begin
					next_cause = tcpf_pkg::CAUSE_FRAG;
				end
				if (r == 11'h009 && LINK.data != tcpf_pkg::IP_PROTO_UDP) begin
					next_cause = tcpf_pkg::CAUSE_HDR;
				end
				if (r == 11'h00f) begin
					next_src_ip = {sh, LINK.data};
				end
				if (r == 11'h013) begin
					next_dst_ip = {sh, LINK.data};
				end
			end
			if (pos >= base && r == 11'h01f) begin
				next_clen = w;
			end
			if (pos >= base && r == 11'h023) begin
				n_conn = {sh, LINK.data};
			end
			if (pos >= base && r == 11'h025) begin
				n_ns = w;
			end
			if (pos >= base && r == 11'h027) begin
				n_nr = w;
				n_recs = 8'h00;
			end
			if (pos >= base && r >= 11'h028 && pos < avp_end) begin
				avp_byte = 1'b1;
				n_avp_valid = 1'b1;
				n_avp_data = LINK.data;
				if (rec_ph) begin
					next_rec_ph = 1'b0;
					next_rec_left = rec_len - 10'h002;
					n_recs = AVP_RECORDS + 8'h01;
					if (rec_len < 10'(tcpf_pkg::AVP_MIN)) begin
						next_cause = tcpf_pkg::CAUSE_AVP;
					end
				end else if (rec_left == 10'h000) begin
					next_rec_ph = 1'b1;
				end else begin
					next_rec_left = rec_left - 10'h001;
				end
			end
		end
		if (fin) begin
			if (verdict == tcpf_pkg::CAUSE_NONE) begin
				if (pos + 11'h001 != avp_end + 11'(tcpf_pkg::CRC_LEN) || next_rec_left != 10'h000 || next_rec_ph
					|| clen < 16'(tcpf_pkg::CTL_LEN)) begin
					verdict = tcpf_pkg::CAUSE_AVP;
				end else if (next_crc != tcpf_pkg::CRC_RESIDUE) begin
					verdict = tcpf_pkg::CAUSE_CRC;
				end else if (tcpf_pkg::csum_fold(sum) != 16'hffff) begin
					verdict = tcpf_pkg::CAUSE_CSUM;
				end else if (dst_ip != MY_IP || (MUTUAL_AUTH && !SA_READY)) begin
					verdict = tcpf_pkg::CAUSE_ADDR;
				end else if (match == '0 && (&slot_used)) begin
					verdict = tcpf_pkg::CAUSE_ADDR;
				end
			end
			// a new core endpoint address takes the lowest free slot
			if (verdict == tcpf_pkg::CAUSE_NONE && match == '0) begin
				for (int i = SLOTS - 1; i >= 0; i--) begin
					if (!slot_used[i]) begin
						next_slot_used = slot_used | (SLOTS'(1) << i);
					end
				end
				for (int i = 0; i < SLOTS; i++) begin
					if (next_slot_used[i] && !slot_used[i]) begin
						next_slot_ip[i] = src_ip;
					end
				end
			end
			n_accept = (verdict == tcpf_pkg::CAUSE_NONE);
			n_drop = !n_accept;
			n_mac = n_accept ? PEER_MAC : PEER_MAC;
			n_peer_ip = n_accept ? src_ip : PEER_IP;
			n_vseen = vlan;
			next_pos = 11'h000;
			next_vlan = 1'b0;
			next_clen = 16'h0000;
			next_sum = 32'h00000000;
			next_crc = tcpf_pkg::CRC_INIT;
			next_rec_left = 10'h000;
			next_rec_ph = 1'b0;
			next_cause = tcpf_pkg::CAUSE_NONE;
		end else if (take && pos >= 11'h006 && pos < 11'h00c) begin
			n_mac = {PEER_MAC[39:0], LINK.data};
		end
	end

	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			pos <= 11'h000;
			sh <= 24'h000000;
			vlan <= 1'b0;
			clen <= 16'h0000;
			sum <= 32'h00000000;
			crc <= tcpf_pkg::CRC_INIT;
			src_ip <= 32'h00000000;
			dst_ip <= 32'h00000000;
			rec_left <= 10'h000;
			rec_ph <= 1'b0;
			cause <= tcpf_pkg::CAUSE_NONE;
			slot_used <= '0;
			for (int i = 0; i < SLOTS; i++) begin
				slot_ip[i] <= 32'h00000000;
			end
			AVP_DATA <= 8'h00;
			AVP_VALID <= 1'b0;
			ACCEPT <= 1'b0;
			DROP <= 1'b0;
			DROP_CAUSE <= tcpf_pkg::CAUSE_NONE;
			CONN_ID <= 32'h00000000;
			NS <= 16'h0000;
			NR <= 16'h0000;
			PEER_IP <= 32'h00000000;
			PEER_MAC <= 48'h000000000000;
			VLAN_SEEN <= 1'b0;
			USER_PRIO <= 3'h0;
			AVP_RECORDS <= 8'h00;
		end else begin
			pos <= next_pos;
			sh <= next_sh;
			vlan <= next_vlan;
			clen <= next_clen;
			sum <= next_sum;
			crc <= next_crc;
			src_ip <= next_src_ip;
			dst_ip <= next_dst_ip;
			rec_left <= next_rec_left;
			rec_ph <= next_rec_ph;
			cause <= next_cause;
			slot_used <= next_slot_used;
			slot_ip <= next_slot_ip;
			AVP_DATA <= n_avp_data;
			AVP_VALID <= n_avp_valid;
			ACCEPT <= n_accept;
			DROP <= n_drop;
			DROP_CAUSE <= fin ? verdict : DROP_CAUSE;
			CONN_ID <= n_conn;
			NS <= n_ns;
			NR <= n_nr;
			PEER_IP <= n_peer_ip;
			PEER_MAC <= n_mac;
			VLAN_SEEN <= n_vseen;
			USER_PRIO <= n_prio;
			AVP_RECORDS <= n_recs;
		end
	end
endmodule

/* verification/tcpf_link_checker.sv */
/*
 checker on the core to remote byte link of the tunnel control packet framer.
 assumes one clock and one async active-low reset shared by both ends.
*/
`timescale 1ns/1ns
module tcpf_link_checker (
	input wire logic CLK,
	input wire logic RESET_N,
	input wire logic [7:0] data,
	input wire logic valid,
	input wire logic last,
	input wire logic ready
);
	// ----
	// byte position within the frame
	// ----
	logic [11:0] idx;
	logic [11:0] next_idx;
	logic tag;
	logic next_tag;
	logic [11:0] ip;
	logic take;
	assign take = valid && ready;
	// ip offset only trusted from byte 13 on, where the tag flag is fresh
	assign ip = tag ? 12'h012 : 12'h00e;
	always_comb begin
		next_idx = idx;
		next_tag = tag;
		if (take) begin
			next_idx = last ? 12'h000 : idx + 12'h001;
			if (idx == 12'h00c) next_tag = (data == 8'h81);
		end
	end
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			idx <= 12'h000;
			tag <= 1'b0;
		end else begin
			idx <= next_idx;
			tag <= next_tag;
		end
	end
	// ----
	// link rules
	// ----
	default clocking @(posedge CLK); endclocking
	default disable iff (!RESET_N);
	hold_offer_a: assert property (valid && !ready |=> valid && $stable(data) && $stable(last))
		else $error("link offer changed before taken");
	reset_idle_a: assert property ($rose(RESET_N) |-> !valid)
		else $error("link valid right after reset");
	frame_min_a: assert property (take && last |-> idx >= 12'h039)
		else $error("frame shorter than headers and crc");
	individual_dst_a: assert property (take && idx == 12'h000 |-> !data[0])
		else $error("group destination address sent");
	ether_type_a: assert property (take && idx == 12'h00c |-> data == 8'h81 || data == 8'h08)
		else $error("bad type after source address");
	ip_version_a: assert property (take && idx == ip |-> data == 8'h45)
		else $error("bad ip version or header length");
	no_split_a: assert property (take && idx == ip + 12'h006 |-> data == 8'h40)
		else $error("no split flag missing");
	frag_offset_a: assert property (take && idx == ip + 12'h007 |-> data == 8'h00)
		else $error("nonzero fragment offset");
	ip_proto_a: assert property (take && idx == ip + 12'h009 |-> data == 8'h11)
		else $error("protocol not udp");
	ctl_flags_a: assert property (take && idx == ip + 12'h01c |-> data == 8'hc8)
		else $error("bad control header flags");
	cover property (take && idx == 12'h00c && data == 8'h81);
	cover property (valid && !ready);
	cover property (take && last);
endmodule

/* verification/tb_top.sv */
/*
 testbench: core end and remote end joined by one link; table of frames, then hand cases.
 assumes both ends share CLK and RESET_N.
*/
`timescale 1ns/1ns
module tb_top;
	typedef struct {logic vl; logic [5:0] ds; logic [10:0] al; logic [31:0] sip; logic [31:0] dip; logic st;
		logic ok;} tcpf_row_t;
	localparam logic [31:0] ME = 32'h0a000002;
	logic CLK = 1'b0;
	logic RESET_N = 1'b0;
	logic start = 1'b0, c_ma = 1'b0, c_sa = 1'b0, r_ma = 1'b0, r_sa = 1'b0, vl = 1'b0, r_rdy = 1'b1, st = 1'b0;
	logic a_vld = 1'b1;
	logic [7:0] ndone = 8'h00;
	logic [47:0] dmac = 48'h020000000002;
	logic [5:0] ds = 6'h00;
	logic [31:0] sip = 32'h0a000001, dip = ME, cid = 32'h00000000;
	logic [10:0] al = 11'h000, a_idx = 11'h000, rx = 11'h000;
	logic [11:0] w_idx = 12'h000;
	logic [7:0] a_data, r_avpd, nrec, w_ds;
	logic a_rdy, busy, done, refused, r_avpv, acc, drop, vseen;
	logic [2:0] prio;
	logic [31:0] r_cid, peer;
	logic [15:0] r_ns, r_nr;
	logic [47:0] pmac;
	tcpf_pkg::tcpf_cause_t cause;
	int fails = 0, n_compared = 0;
	tcpf_row_t rows [7] = '{
		'{1'b0, 6'h2e, 11'h000, 32'h0a000011, ME, 1'b0, 1'b1},
		'{1'b1, 6'h3f, 11'h006, 32'h0a000012, ME, 1'b1, 1'b1},
		'{1'b0, 6'h0a, 11'h00c, 32'h0a000013, ME, 1'b0, 1'b1},
		'{1'b1, 6'h08, 11'h012, 32'h0a000014, ME, 1'b1, 1'b1},
		'{1'b0, 6'h00, 11'h006, 32'h0a000015, ME, 1'b0, 1'b0},
		'{1'b1, 6'h1c, 11'h006, 32'h0a000011, ME, 1'b0, 1'b1},
		'{1'b0, 6'h00, 11'h006, 32'h0a000011, 32'h0a000009, 1'b0, 1'b0}};
	tcpf_link_if link ();
	// records of six bytes: flag byte, then length
	assign a_data = (a_idx % 11'h006 == 11'h001) ? 8'h06 : ((a_idx % 11'h006 == 11'h000) ? 8'h80 : a_idx[7:0]);
	tcpf_core_end tcpf_core_end_inst (.CLK(CLK), .RESET_N(RESET_N), .LINK(link.core_end), .START(start),
		.MUTUAL_AUTH(c_ma), .SA_READY(c_sa), .DST_MAC(dmac), .SRC_MAC({16'h02aa, sip}), .VLAN_EN(vl),
		.VLAN_ID(12'h123), .DSCP(ds), .SRC_IP(sip), .DST_IP(dip), .SRC_PORT(cid[31:16]), .DST_PORT(16'h06a5),
		.CONN_ID(cid), .NS(cid[15:0]), .NR(cid[31:16]), .IDENT(cid[15:0]), .AVP_LEN(al), .AVP_DATA(a_data),
		.AVP_VALID(a_vld), .AVP_READY(a_rdy), .BUSY(busy), .DONE(done), .REFUSED(refused));
	tcpf_remote_end tcpf_remote_end_inst (.CLK(CLK), .RESET_N(RESET_N), .LINK(link.remote_end), .MY_IP(ME),
		.MUTUAL_AUTH(r_ma), .SA_READY(r_sa), .AVP_READY(r_rdy), .AVP_DATA(r_avpd), .AVP_VALID(r_avpv),
		.ACCEPT(acc), .DROP(drop), .DROP_CAUSE(cause), .CONN_ID(r_cid), .NS(r_ns), .NR(r_nr), .PEER_IP(peer),
		.PEER_MAC(pmac), .VLAN_SEEN(vseen), .USER_PRIO(prio), .AVP_RECORDS(nrec));
	tcpf_link_checker tcpf_link_checker_inst (.CLK(CLK), .RESET_N(RESET_N), .data(link.data),
		.valid(link.valid), .last(link.last), .ready(link.ready));
	// ----
	// clock, sources and wire taps
	// ----
	initial forever #10 CLK = ~CLK;
	// stall toggles the far user so the two-entry buffer fills
	always @(posedge CLK) begin
		if (a_vld && a_rdy) a_idx <= a_idx + 11'h001;
		// source gaps only after a take, so an offer is never withdrawn
		if (!a_vld || a_rdy) a_vld <= st ? ~a_vld : 1'b1;
		if (r_avpv && r_rdy) begin
			rx <= rx + 11'h001;
			check(r_avpd, (rx % 11'h006 == 11'h001) ? 8'h06
				: ((rx % 11'h006 == 11'h000) ? 8'h80 : rx[7:0]));
		end
		if (done) ndone <= ndone + 8'h01;
		r_rdy <= st ? ~r_rdy : 1'b1;
	end
	always @(posedge CLK) begin
		if (!RESET_N) begin
			w_idx <= 12'h000;
		end else if (link.valid && link.ready) begin
			w_idx <= link.last ? 12'h000 : w_idx + 12'h001;
			if (w_idx == (vl ? 12'h013 : 12'h00f)) w_ds <= link.data;
		end
	end
	// ----
	// tasks
	// ----
	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		n_compared++;
		if (seen !== exp) begin
			fails++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic test_done;
		$display("compared %0d failed %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	// verdict: 1 accept, 2 drop, 3 refused
	task automatic go(output logic [1:0] v);
		v = 2'h0;
		@(posedge CLK);
		a_idx <= 11'h000;
		rx <= 11'h000;
		start <= 1'b1;
		@(posedge CLK);
		start <= 1'b0;
		// refused stands only for the cycle right after start
		#1;
		if (refused === 1'b1) v = 2'h3;
		for (int n = 0; n < 400 && v == 2'h0; n++) begin
			@(posedge CLK);
			#1;
			if (refused === 1'b1) v = 2'h3;
			if (acc === 1'b1) v = 2'h1;
			if (drop === 1'b1) v = 2'h2;
		end
	endtask
	task automatic expect_v(input logic [1:0] e);
		logic [1:0] v;
		go(v);
		check(v, e);
	endtask
	// ----
	// main sequence
	// ----
	initial begin
		logic [1:0] v;
		tcpf_row_t r;
		repeat (12) @(posedge CLK);
		check({busy, done, acc, drop, link.valid}, 64'h0);
		RESET_N <= 1'b1;
		foreach (rows[i]) begin
			r = rows[i];
			@(posedge CLK);
			vl <= r.vl;
			ds <= r.ds;
			al <= r.al;
			sip <= r.sip;
			dip <= r.dip;
			st <= r.st;
			cid <= {24'h5a0001, 8'(i)};
			go(v);
			check(v, {~r.ok, r.ok});
			check(cause, r.ok ? tcpf_pkg::CAUSE_NONE : tcpf_pkg::CAUSE_ADDR);
			check({r_cid, r_ns, r_nr}, {cid, cid[15:0], cid[31:16]});
			check({vseen, nrec, rx}, {r.vl, 8'(r.al / 11'h006), r.al});
			check(w_ds, {r.ds, 2'h0});
			check(pmac, {16'h02aa, r.sip});
			if (r.vl) check(prio, r.ds[5:3]);
			if (r.ok) check(peer, r.sip);
		end
		check(ndone, 8'h07);
		@(posedge CLK);
		dmac <= 48'h030000000002;
		al <= 11'h000;
		dip <= ME;
		expect_v(2'h3);
		@(posedge CLK);
		dmac <= 48'h020000000002;
		al <= 11'h5b5;
		expect_v(2'h3);
		@(posedge CLK);
		al <= 11'h006;
		c_ma <= 1'b1;
		r_ma <= 1'b1;
		expect_v(2'h3);
		@(posedge CLK);
		c_sa <= 1'b1;
		expect_v(2'h2);
		@(posedge CLK);
		r_sa <= 1'b1;
		expect_v(2'h1);
		@(posedge CLK);
		sip <= 32'h0a000015;
		al <= 11'h00c;
		start <= 1'b1;
		@(posedge CLK);
		start <= 1'b0;
		repeat (30) @(posedge CLK);
		RESET_N <= 1'b0;
		@(posedge CLK);
		#1;
		check({busy, link.valid, acc, drop}, 64'h0);
		@(posedge CLK);
		RESET_N <= 1'b1;
		expect_v(2'h1);
		test_done();
	end
	initial begin
		repeat (20000) @(posedge CLK);
		fails++;
		test_done();
	end
endmodule
